// ==== chirq_defs.svh ====
/*
 * Register offsets, field positions and reset values of the channel
 * interrupt aggregator. Assumes an 8-bit address and 8-bit data port.
 */
`ifndef CHIRQ_DEFS_SVH
`define CHIRQ_DEFS_SVH
`define CHIRQ_GATE_LOW_ADDR 8'h60
`define CHIRQ_SUMMARY_LOW_ADDR 8'h61
`define CHIRQ_GATE_HIGH_ADDR 8'he0
`define CHIRQ_SUMMARY_HIGH_ADDR 8'he1
`define CHIRQ_SRC_STATUS_LSN 4'h2
`define CHIRQ_GROUP_WIDTH 6
`define CHIRQ_GATE_RESET 6'h00
`define CHIRQ_RESERVED_READ 2'h0
`define CHIRQ_UNMAPPED_READ 8'h00
`define CHIRQ_RDATA_RESET 8'h00
`define CHIRQ_SUMMARY_RESET 1'b0
`define CHIRQ_INT_RESET 1'b0
`define CHIRQ_CHANNEL_FIELD_MSB 7
`define CHIRQ_CHANNEL_FIELD_LSB 4
`define CHIRQ_OFFSET_FIELD_MSB 3
`define CHIRQ_OFFSET_FIELD_LSB 0
`endif

// ==== chirq_pkg.sv ====
/*
 * Types shared by the channel interrupt aggregator.
 * Assumes nothing beyond the definitions header.
 */
package chirq_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_s;
endpackage

// ==== channel_irq_aggregator.sv ====
/*
 * Channel-level interrupt aggregation for a twelve channel line unit:
 * the per-channel pending summaries, the two channel gate registers and
 * the host interrupt pin.
 * Assumes a register port whose read and write strobes are one-cycle
 * pulses synchronous to MCLK_I, and per-channel levels that already
 * combine each channel's source-level status with its source-level enables.
 */

`include "chirq_defs.svh"

module channel_irq_aggregator #(
	parameter int CHANNELS = 12
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire chirq_pkg::host_req_s HOST_REQ_I,
	input wire logic [CHANNELS-1:0] SRC_PENDING_I,
	output logic [7:0] RDATA_O,
	output logic [CHANNELS-1:0] SRC_STATUS_READ_O,
	output logic INT_N_O
);
	localparam int GW = `CHIRQ_GROUP_WIDTH;

	// Register port decode.
	logic [7:0] addr;
	logic rd_taken;
	logic wr_taken;
	logic hit_gate_low;
	logic hit_gate_high;
	logic hit_sum_low;
	logic hit_sum_high;
	logic hit_src_offset;
	logic hit_src_status;
	logic [3:0] src_channel;
	logic wr_gate_low;
	logic wr_gate_high;

	// Channel gate registers.
	logic [GW-1:0] gate_low_r;
	logic [GW-1:0] gate_low_nxt;
	logic [GW-1:0] gate_high_r;
	logic [GW-1:0] gate_high_nxt;
	logic [CHANNELS-1:0] gate_all_nxt;

	// Pending summaries.
	logic [CHANNELS-1:0] summary_r;
	logic [CHANNELS-1:0] summary_nxt;
	logic [CHANNELS-1:0] src_read;
	logic [CHANNELS-1:0] gated_pending;

	// Read path.
	logic [7:0] sum_low_word;
	logic [7:0] sum_high_word;
	logic [7:0] gate_low_word;
	logic [7:0] gate_high_word;
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;

	// Interrupt pin.
	logic int_nxt;
	logic int_r;

	assign addr = HOST_REQ_I.addr;
	assign rd_taken = HOST_REQ_I.rd;
	assign wr_taken = HOST_REQ_I.wr;

	assign hit_gate_low = addr == `CHIRQ_GATE_LOW_ADDR;
	assign hit_gate_high = addr == `CHIRQ_GATE_HIGH_ADDR;
	assign hit_sum_low = addr == `CHIRQ_SUMMARY_LOW_ADDR;
	assign hit_sum_high = addr == `CHIRQ_SUMMARY_HIGH_ADDR;

	// The channel number sits in the upper nibble of the source status address.
	assign src_channel = addr[`CHIRQ_CHANNEL_FIELD_MSB:`CHIRQ_CHANNEL_FIELD_LSB];
	assign hit_src_offset =
		addr[`CHIRQ_OFFSET_FIELD_MSB:`CHIRQ_OFFSET_FIELD_LSB] == `CHIRQ_SRC_STATUS_LSN;
	assign hit_src_status = rd_taken && hit_src_offset;

	assign wr_gate_low = wr_taken && hit_gate_low;
	assign wr_gate_high = wr_taken && hit_gate_high;

	// Writes to any other address fall through untouched.
	assign gate_low_nxt = wr_gate_low ? HOST_REQ_I.wdata[GW-1:0] : gate_low_r;
	assign gate_high_nxt = wr_gate_high ? HOST_REQ_I.wdata[GW-1:0] : gate_high_r;

	// The pin follows the gate values being written, so a gate change
	// shows on the pin at the same edge as in the register.
	assign gate_all_nxt = {gate_high_nxt, gate_low_nxt};

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			assign src_read[ch] = hit_src_status && src_channel == 4'(ch);

			// A new event wins over a clearing read in the same cycle,
			// so an event arriving during the read is never lost.
			assign summary_nxt[ch] =
				SRC_PENDING_I[ch] | (summary_r[ch] & ~src_read[ch]);

			// Summaries of gated-off channels still set, so polling works.
			assign gated_pending[ch] = summary_nxt[ch] & gate_all_nxt[ch];
		end
	endgenerate

	assign int_nxt = |gated_pending;

	assign sum_low_word = {`CHIRQ_RESERVED_READ, summary_r[GW-1:0]};
	assign sum_high_word = {`CHIRQ_RESERVED_READ, summary_r[CHANNELS-1:GW]};
	assign gate_low_word = {`CHIRQ_RESERVED_READ, gate_low_r};
	assign gate_high_word = {`CHIRQ_RESERVED_READ, gate_high_r};

	// Source status registers live outside this block; reading them here
	// clears the summary and pulses SRC_STATUS_READ_O, and this read path returns the unmapped value.
	assign rdata_nxt =
		hit_sum_low ? sum_low_word :
		hit_sum_high ? sum_high_word :
		hit_gate_low ? gate_low_word :
		hit_gate_high ? gate_high_word :
		`CHIRQ_UNMAPPED_READ;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			gate_low_r <= `CHIRQ_GATE_RESET;
		end else begin
			gate_low_r <= gate_low_nxt;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			gate_high_r <= `CHIRQ_GATE_RESET;
		end else begin
			gate_high_r <= gate_high_nxt;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			summary_r <= {CHANNELS{`CHIRQ_SUMMARY_RESET}};
		end else begin
			summary_r <= summary_nxt;
		end
	end

	// Read data holds between reads so a slow host can take it late.
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_r <= `CHIRQ_RDATA_RESET;
		end else if (rd_taken) begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			int_r <= `CHIRQ_INT_RESET;
		end else begin
			int_r <= int_nxt;
		end
	end

	assign RDATA_O = rdata_r;
	assign SRC_STATUS_READ_O = src_read;
	assign INT_N_O = ~int_r;
endmodule

// ==== chirq_monitor.sv ====
/*
 * Port checker of the channel interrupt aggregator.
 * Assumes it is bound into the aggregator and sees only its ports.
 */
module chirq_monitor #(
	parameter int CHANNELS = 12
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic INT_N_O,
	input wire chirq_pkg::host_req_s HOST_REQ_I,
	input wire logic [CHANNELS-1:0] SRC_PENDING_I,
	input wire logic [CHANNELS-1:0] SRC_STATUS_READ_O,
	input wire logic [7:0] RDATA_O
);
	timeunit 1ns / 1ns;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	wire logic r = HOST_REQ_I.rd, w = HOST_REQ_I.wr;
	wire logic [7:0] a = HOST_REQ_I.addr, d = HOST_REQ_I.wdata, q = RDATA_O;
	wire logic [CHANNELS-1:0] p = SRC_PENDING_I;
	chk_rsv_zero: assert property (r |=> q[7:6] == 2'h0) else $error("rsv");
	chk_sum_low: assert property (r && a == 8'h61 |=> &(q[5:0] | ~$past(p[5:0], 2)))
		else $error("lo");
	chk_sum_high: assert property (r && a == 8'he1 |=> &(q[5:0] | ~$past(p[11:6], 2)))
		else $error("hi");
	chk_sum_hold: assert property (!INT_N_O && !w && SRC_STATUS_READ_O == '0
		|=> !INT_N_O) else $error("hold");
	chk_src_read: assert property (r && a == 8'h32
		|-> SRC_STATUS_READ_O[3] && $onehot(SRC_STATUS_READ_O)) else $error("src");
	chk_gate_low: assert property (w && a == 8'h60 ##2 r && a == 8'h60
		|=> q == {2'h0, $past(d[5:0], 3)}) else $error("g0");
	chk_gate_high: assert property (w && a == 8'he0 ##2 r && a == 8'he0
		|=> q == {2'h0, $past(d[5:0], 3)}) else $error("g1");
	chk_int_cause: assert property ($fell(INT_N_O) && !$past(w) |-> $past(p) != '0)
		else $error("int");
	cover property (!INT_N_O);
	cover property (SRC_STATUS_READ_O != 0);
	cover property (r && a == 8'he1);
endmodule
bind channel_irq_aggregator chirq_monitor #(.CHANNELS(CHANNELS)) u_mon(.*);

// ==== chirq_host.sv ====
/* Host model on the register port. Assumes the bench clock. */
module chirq_host (
	input wire logic MCLK_I,
	output chirq_pkg::host_req_s REQ_O
);
	timeunit 1ns / 1ns;
	initial REQ_O = '0;
	// An idle cycle between accesses keeps every strobe a clean one-cycle pulse.
	task acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
		@(posedge MCLK_I) #1 REQ_O = {!w, w, ad, d};
		@(posedge MCLK_I) #1 REQ_O = '0;
	endtask
endmodule

// ==== channel_irq_aggregator_tb_top.sv ====
/* Bench of the aggregator. Assumes the host model and the port checker. */
module channel_irq_aggregator_tb_top;
	timeunit 1ns / 1ns;
	logic MCLK_I = 0, RST_N_I = 0, int_n;
	logic [11:0] pend = '0, sr;
	logic [7:0] rdata;
	chirq_pkg::host_req_s req;
	int err_total = 0, tests_run = 0, cyc = 0;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t %h %h", $time, g, e); end end
	initial forever #25 MCLK_I = ~MCLK_I;
	always @(posedge MCLK_I) if (++cyc > 2000) begin err_total++; summarize(); end
	chirq_host u_host(.MCLK_I(MCLK_I), .REQ_O(req));
	channel_irq_aggregator u_dut(.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .HOST_REQ_I(req),
		.SRC_PENDING_I(pend), .RDATA_O(rdata), .SRC_STATUS_READ_O(sr), .INT_N_O(int_n));
	task summarize();
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e); u_host.acc(1'b0, a, 8'h00); `CHK(rdata, e) endtask
	task pulse(input logic [11:0] v); @(posedge MCLK_I) #1 pend = v; @(posedge MCLK_I) #1 pend = '0; endtask
	initial begin
		repeat (16) @(posedge MCLK_I);
		#1 RST_N_I = 1;
		rdc(8'he0, 8'h00);
		u_host.acc(1'b1, 8'h60, 8'hff);
		rdc(8'h60, 8'h3f);
		u_host.acc(1'b1, 8'he0, 8'h2a);
		rdc(8'he0, 8'h2a);
		pulse(12'h040);
		`CHK(int_n, 1'b1)
		rdc(8'he1, 8'h01);
		pulse(12'h008);
		`CHK(int_n, 1'b0)
		rdc(8'h61, 8'h08);
		rdc(8'h61, 8'h08);
		u_host.acc(1'b0, 8'h32, 8'h00);
		rdc(8'h61, 8'h00);
		`CHK(int_n, 1'b1)
		rdc(8'h55, 8'h00);
		summarize();
	end
endmodule
